/* hw/ide_bus_port.sv */
// Sixteen-bit external move bus port towards IDE/ATAPI devices
// How it works
// R1: Wide enable makes each move sixteen bits
// R2: Low port low byte, high port high byte
// R3: Write drives working register and high register
// R4: Read returns low byte, captures high byte
// R5: Each bus cycle lasts six CPU clocks, 18 when stretched
// R6: Strobe lasts 3 clocks, 15 when stretched
// R7: Index-register move puts port register high
// R8: Page mode pointer move puts port register high
// R9: Latch strobe marks valid low address
// R10: Device uses read/write strobes as I/O commands
// R11: Up to two devices, controls external
// R12: Address before latch falls; release before read
`default_nettype none
module ide_bus_port (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       wide_transfer_enable,
  input  wire logic       strobe_stretch_bit,
  input  wire logic       page_access_mode_bit,
  input  wire logic       move_req,
  input  wire logic       move_write,
  input  wire logic       move_via_index,
  input  wire logic [15:0] move_addr,
  input  wire logic [7:0] cpu_working_register_in,
  input  wire logic [7:0] high_port_reg,
  input  wire logic       hdb_load,
  input  wire logic [7:0] hdb_wdata,
  input  wire logic [7:0] low_port_in,
  input  wire logic [7:0] high_port_in,
  output logic            move_busy,
  output logic            move_done,
  output logic [7:0]      cpu_working_register_out,
  output logic [7:0]      high_data_byte_register,
  output logic [7:0]      low_port_out,
  output logic            low_port_oe,
  output logic [7:0]      high_port_out,
  output logic            high_port_oe,
  output logic            ale,
  output logic            rd_n,
  output logic            wr_n
);
  logic                rst_meta_r;
  logic                rst_n_s;
  pin_sync_if          pins ();

  ide_pkg::phase_t     state_r, state_nxt;
  logic [3:0]          cnt_r, cnt_nxt;
  logic [3:0]          strobe_len_r, strobe_len_nxt;
  logic                wr_lat_r, wr_lat_nxt;
  logic                wide_lat_r, wide_lat_nxt;
  logic [15:0]         addr_r, addr_nxt;
  logic [15:0]         wdata_r, wdata_nxt;
  logic                busy_r, busy_nxt;
  logic                done_r, done_nxt;
  logic [7:0]          rdata_r, rdata_nxt;
  logic [7:0]          hdb_r, hdb_nxt;
  logic [7:0]          lo_out_r, lo_out_nxt;
  logic                lo_oe_r, lo_oe_nxt;
  logic [7:0]          hi_out_r, hi_out_nxt;
  logic                hi_oe_r, hi_oe_nxt;
  logic                ale_r, ale_nxt;
  logic                rd_n_r, rd_n_nxt;
  logic                wr_n_r, wr_n_nxt;
  logic                start;
  logic                use_port_hi;

  // Reset enters asynchronously but is released on clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  assign pins.raw = {high_port_in, low_port_in};

  pin_sync u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n_s),
    .pins  (pins)
  );

  assign start       = move_req && (state_r == ide_pkg::PH_IDLE);
  assign use_port_hi = move_via_index || page_access_mode_bit; // R7 R8

  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    strobe_len_nxt = strobe_len_r;
    wr_lat_nxt     = wr_lat_r;
    wide_lat_nxt   = wide_lat_r;
    addr_nxt       = addr_r;
    wdata_nxt      = wdata_r;
    rdata_nxt      = rdata_r;
    hdb_nxt        = hdb_r;
    done_nxt       = 1'b0;
    if (hdb_load) begin
      hdb_nxt = hdb_wdata;
    end
    unique case (state_r)
      ide_pkg::PH_IDLE: begin
        // Requests made while busy are simply not taken
        if (move_req) begin
          state_nxt      = ide_pkg::PH_ADDR;
          wr_lat_nxt     = move_write;
          wide_lat_nxt   = wide_transfer_enable; // R1
          strobe_len_nxt = strobe_stretch_bit ? // R6
                           ide_pkg::STROBE_STRETCH_CLKS :
                           ide_pkg::STROBE_CLKS;
          addr_nxt       = {use_port_hi ? high_port_reg : move_addr[15:8],
                            move_addr[7:0]}; // R7 R8
          // Software load in the same cycle is what gets written
          wdata_nxt      = {hdb_load ? hdb_wdata : hdb_r,
                            cpu_working_register_in}; // R3
        end
      end
      ide_pkg::PH_ADDR: state_nxt = ide_pkg::PH_HOLD;
      ide_pkg::PH_HOLD: begin
        state_nxt = ide_pkg::PH_STRB;
        cnt_nxt   = ide_pkg::CNT_RST;
      end
      ide_pkg::PH_STRB: begin
        if (cnt_r == strobe_len_r - ide_pkg::CNT_ONE) begin // R6
          state_nxt = ide_pkg::PH_END;
        end else begin
          cnt_nxt = cnt_r + ide_pkg::CNT_ONE;
        end
      end
      ide_pkg::PH_END: begin
        state_nxt = ide_pkg::PH_IDLE; // R5
        done_nxt  = 1'b1;
        if (!wr_lat_r) begin
          rdata_nxt = pins.synced[7:0]; // R4
          // Captured byte wins over a software load in this cycle
          if (wide_lat_r) begin
            hdb_nxt = pins.synced[15:8]; // R4
          end
        end
      end
    endcase
  end

  // Pin values follow the next phase so every output is a flop
  always_comb begin
    ale_nxt    = (state_nxt == ide_pkg::PH_ADDR); // R9
    rd_n_nxt   = !((state_nxt == ide_pkg::PH_STRB) && !wr_lat_nxt);
    wr_n_nxt   = !((state_nxt == ide_pkg::PH_STRB) && wr_lat_nxt);
    busy_nxt   = (state_nxt != ide_pkg::PH_IDLE);
    lo_out_nxt = addr_nxt[7:0];
    hi_out_nxt = addr_nxt[15:8];
    lo_oe_nxt  = 1'b0;
    hi_oe_nxt  = 1'b0;
    unique case (state_nxt)
      ide_pkg::PH_IDLE: begin
        lo_oe_nxt = 1'b0;
      end
      ide_pkg::PH_ADDR: begin
        lo_oe_nxt = 1'b1; // R12
        hi_oe_nxt = 1'b1; // R2
      end
      ide_pkg::PH_HOLD, ide_pkg::PH_STRB, ide_pkg::PH_END: begin
        if (wr_lat_nxt) begin
          lo_out_nxt = wdata_nxt[7:0]; // R2 R3
          lo_oe_nxt  = 1'b1;
          hi_oe_nxt  = 1'b1;
          if (wide_lat_nxt) begin
            hi_out_nxt = wdata_nxt[15:8]; // R3
          end
        end else begin
          // Low lines, and high lines on a wide read, are freed a clock before the read strobe falls
          lo_oe_nxt = 1'b0; // R12
          hi_oe_nxt = !wide_lat_nxt; // R1 R12
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r      <= ide_pkg::PH_IDLE;
      cnt_r        <= ide_pkg::CNT_RST;
      strobe_len_r <= ide_pkg::STROBE_CLKS;
      wr_lat_r     <= 1'b0;
      wide_lat_r   <= 1'b0;
      addr_r       <= ide_pkg::WORD_RST;
      wdata_r      <= ide_pkg::WORD_RST;
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
      rdata_r      <= ide_pkg::HDB_RST;
      hdb_r        <= ide_pkg::HDB_RST;
      lo_out_r     <= ide_pkg::HDB_RST;
      lo_oe_r      <= 1'b0;
      hi_out_r     <= ide_pkg::HDB_RST;
      hi_oe_r      <= 1'b0;
      ale_r        <= 1'b0;
      rd_n_r       <= 1'b1;
      wr_n_r       <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      strobe_len_r <= strobe_len_nxt;
      wr_lat_r     <= wr_lat_nxt;
      wide_lat_r   <= wide_lat_nxt;
      addr_r       <= addr_nxt;
      wdata_r      <= wdata_nxt;
      busy_r       <= busy_nxt;
      done_r       <= done_nxt;
      rdata_r      <= rdata_nxt;
      hdb_r        <= hdb_nxt;
      lo_out_r     <= lo_out_nxt;
      lo_oe_r      <= lo_oe_nxt;
      hi_out_r     <= hi_out_nxt;
      hi_oe_r      <= hi_oe_nxt;
      ale_r        <= ale_nxt;
      rd_n_r       <= rd_n_nxt;
      wr_n_r       <= wr_n_nxt;
    end
  end

  assign move_busy                = busy_r;
  assign move_done                = done_r;
  assign cpu_working_register_out = rdata_r;
  assign high_data_byte_register  = hdb_r;
  assign low_port_out             = lo_out_r;
  assign low_port_oe              = lo_oe_r;
  assign high_port_out            = hi_out_r;
  assign high_port_oe             = hi_oe_r;
  assign ale                      = ale_r;
  assign rd_n                     = rd_n_r;
  assign wr_n                     = wr_n_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  property p_cycle_len;
    start && !strobe_stretch_bit |-> ##7 done_r;
  endproperty
  a_cycle_len: assert property (p_cycle_len) // R5
    else $error("normal bus cycle not six clocks");
  property p_stretch_len;
    start && strobe_stretch_bit |-> ##19 done_r;
  endproperty
  a_stretch_len: assert property (p_stretch_len) // R6
    else $error("stretched bus cycle has wrong length");
  property p_strobe_short;
    $fell(rd_n_r && wr_n_r) && strobe_len_r == ide_pkg::STROBE_CLKS
      |-> (!(rd_n_r && wr_n_r))[*3] ##1 (rd_n_r && wr_n_r);
  endproperty
  a_strobe_short: assert property (p_strobe_short) // R6
    else $error("strobe not three clocks wide");
  property p_strobe_long;
    $fell(rd_n_r && wr_n_r) && strobe_len_r == ide_pkg::STROBE_STRETCH_CLKS
      |-> ##14 !(rd_n_r && wr_n_r) ##1 (rd_n_r && wr_n_r);
  endproperty
  a_strobe_long: assert property (p_strobe_long) // R6
    else $error("stretched strobe not fifteen clocks");
  property p_ale_addr;
    ale_r |-> lo_oe_r && hi_oe_r && lo_out_r == addr_r[7:0]
      && hi_out_r == addr_r[15:8];
  endproperty
  a_ale_addr: assert property (p_ale_addr) // R9
    else $error("address not driven while latch strobe high");
  property p_rd_release;
    $fell(rd_n_r) |-> !lo_oe_r && !$past(lo_oe_r)
      && (!wide_lat_r || (!hi_oe_r && !$past(hi_oe_r)));
  endproperty
  a_rd_release: assert property (p_rd_release) // R12
    else $error("port still driven at read strobe");
  property p_wr_data;
    !wr_n_r |-> lo_out_r == wdata_r[7:0] && lo_oe_r
      && (!wide_lat_r || hi_out_r == wdata_r[15:8]);
  endproperty
  a_wr_data: assert property (p_wr_data) // R3
    else $error("write data not on ports during strobe");
  property p_rd_capture;
    done_r && !wr_lat_r |-> rdata_r == $past(pins.synced[7:0])
      && (!wide_lat_r || hdb_r == $past(pins.synced[15:8]));
  endproperty
  a_rd_capture: assert property (p_rd_capture) // R4
    else $error("read bytes not captured");
  property p_port_high;
    start && use_port_hi |-> ##1 ale_r && hi_out_r == $past(high_port_reg);
  endproperty
  a_port_high: assert property (p_port_high) // R7
    else $error("high port does not show port register");
  property p_narrow;
    !wr_n_r && !wide_lat_r |-> hi_out_r == addr_r[15:8];
  endproperty
  a_narrow: assert property (p_narrow) // R1
    else $error("narrow write changed high port");
endmodule : ide_bus_port
`default_nettype wire

/* hw/pin_sync.sv */
// Two-flop synchroniser for the port input pins
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  pin_sync_if.sync  pins
);
  logic [ide_pkg::BUS_W-1:0] meta_r;
  logic [ide_pkg::BUS_W-1:0] meta_nxt;
  logic [ide_pkg::BUS_W-1:0] sync_r;
  logic [ide_pkg::BUS_W-1:0] sync_nxt;

  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = pins.raw;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= ide_pkg::WORD_RST;
      sync_r <= ide_pkg::WORD_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pins.synced = sync_r;
endmodule : pin_sync
`default_nettype wire

/* include/ide_pkg.sv */
// Constants and types shared by the sixteen-bit bus port
`default_nettype none
package ide_pkg;
  localparam int          BYTE_W              = 8;
  localparam int          BUS_W               = 16;
  // One clk period is one CPU clock period
  localparam int          CPU_CLK_NS          = 10;
  localparam int          CYCLE_CLKS          = 6;
  localparam logic [3:0]  STROBE_CLKS         = 4'h3;
  localparam logic [3:0]  STROBE_STRETCH_CLKS = 4'hf;
  localparam logic [7:0]  HDB_RST             = 8'h00;
  localparam logic [15:0] WORD_RST            = 16'h0000;
  localparam logic [3:0]  CNT_RST             = 4'h0;
  localparam logic [3:0]  CNT_ONE             = 4'h1;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_HOLD,
    PH_STRB,
    PH_END
  } phase_t;
endpackage : ide_pkg
`default_nettype wire

/* include/pin_sync_if.sv */
// Raw and synchronised copies of the sixteen port input pins
`default_nettype none
interface pin_sync_if;
  logic [ide_pkg::BUS_W-1:0] raw;
  logic [ide_pkg::BUS_W-1:0] synced;
  modport src  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pin_sync_if
`default_nettype wire

/* testbench/ide_bus_port_test.sv */
// Self-checking bench for the sixteen-bit bus port
`default_nettype none
module ide_bus_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, nrst, wide_transfer_enable, strobe_stretch_bit;
  logic        page_access_mode_bit, move_req, move_write, move_via_index;
  logic        hdb_load, move_busy, move_done, low_port_oe, high_port_oe;
  logic        ale, rd_n, wr_n;
  logic [15:0] move_addr, dev_adr, dev_wd;
  logic [7:0]  cpu_working_register_in, high_port_reg, hdb_wdata;
  logic [7:0]  low_port_in, high_port_in, cpu_working_register_out;
  logic [7:0]  high_data_byte_register, low_port_out, high_port_out;
  int          n_errors, checks, ncyc, nstb, oebad, nbsy;

  ide_bus_port dut_u (.clk, .nrst, .wide_transfer_enable,
    .strobe_stretch_bit, .page_access_mode_bit, .move_req, .move_write,
    .move_via_index, .move_addr, .cpu_working_register_in, .high_port_reg,
    .hdb_load, .hdb_wdata, .low_port_in, .high_port_in, .move_busy,
    .move_done, .cpu_working_register_out, .high_data_byte_register,
    .low_port_out, .low_port_oe, .high_port_out, .high_port_oe, .ale,
    .rd_n, .wr_n);

  ide_dev_model dev_u (.clk, .ale, .rd_n, .wr_n, .lo_out(low_port_out),
    .hi_out(high_port_out), .lo_in(low_port_in), .hi_in(high_port_in),
    .adr(dev_adr), .wd(dev_wd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Loads the high byte, issues one move, then counts clocks to done
  task automatic mv(input logic w, wd, st, ix, pg, input logic [15:0] a,
                    input logic [7:0] lo, hi, ph);
    @(posedge clk);
    #1;
    hdb_load = 1'b1;
    hdb_wdata = hi;
    @(posedge clk);
    #1;
    hdb_load = 1'b0;
    move_req = 1'b1;
    move_write = w;
    wide_transfer_enable = wd;
    strobe_stretch_bit = st;
    move_via_index = ix;
    page_access_mode_bit = pg;
    move_addr = a;
    cpu_working_register_in = lo;
    high_port_reg = ph;
    @(posedge clk);
    #1;
    move_req = 1'b0;
    ncyc = 1;
    nstb = 0;
    oebad = 0;
    nbsy = (move_busy === 1'h1) ? 1 : 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (move_busy === 1'h1)
        nbsy++;
      if (!rd_n || !wr_n)
        nstb++;
      if (!rd_n && (low_port_oe || high_port_oe))
        oebad++;
      if (move_done === 1'b1)
        break;
      ncyc++;
    end
  endtask : mv

  initial begin
    {nrst, wide_transfer_enable, strobe_stretch_bit, page_access_mode_bit,
     move_req, move_write, move_via_index, hdb_load, move_addr,
     cpu_working_register_in, high_port_reg, hdb_wdata} = '0;
    n_errors = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    mv(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'h1234, 8'h9c, 8'h3e, 8'h00);
    chk(dev_adr, 16'h1234);
    chk(dev_wd, 16'h3e9c);
    chk(16'(ncyc), 16'(ide_pkg::CYCLE_CLKS));
    chk(16'(nbsy), 16'(ide_pkg::CYCLE_CLKS));
    chk(16'(nstb), 16'(ide_pkg::STROBE_CLKS));
    $display("wide write done");
    mv(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 16'h8421, 8'h00, 8'h11, 8'h00);
    chk({high_data_byte_register, cpu_working_register_out}, 16'h217b);
    chk(16'(oebad), 16'h0000);
    $display("wide read done");
    mv(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 16'hc30f, 8'h00, 8'h11, 8'h00);
    chk({high_data_byte_register, cpu_working_register_out}, 16'h6655);
    chk(16'(ncyc), 16'h0012);
    chk(16'(nbsy), 16'h0012);
    chk(16'(nstb), 16'(ide_pkg::STROBE_STRETCH_CLKS));
    $display("stretched read done");
    mv(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0f96, 8'h00, 8'h77, 8'h00);
    chk({high_data_byte_register, cpu_working_register_out}, 16'h77cc);
    $display("narrow read done");
    mv(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 16'h5a3c, 8'hd2, 8'h44, 8'h00);
    chk(dev_wd, 16'h5ad2);
    chk(16'(ncyc), 16'(ide_pkg::CYCLE_CLKS));
    $display("narrow write done");
    mv(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 16'hbeef, 8'h10, 8'h20, 8'h42);
    chk(dev_adr, 16'h42ef);
    chk(dev_wd, 16'h2010);
    $display("index write done");
    mv(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'hdead, 8'h00, 8'h11, 8'h5c);
    chk(dev_adr, 16'h5cad);
    chk({high_data_byte_register, cpu_working_register_out}, 16'hf9f7);
    $display("page read done");
    wrap_up();
  end

  // Seven moves of at most 30 clocks each; ten times that cuts a hang
  initial begin
    #21000;
    n_errors++;
    wrap_up();
  end
endmodule : ide_bus_port_test
`default_nettype wire

/* testbench/ide_dev_model.sv */
// Behavioural IDE device sitting on the multiplexed port pins
`default_nettype none
module ide_dev_model (
  input  wire logic        clk,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  lo_out,
  input  wire logic [7:0]  hi_out,
  output logic      [7:0]  lo_in,
  output logic      [7:0]  hi_in,
  output logic      [15:0] adr,
  output logic      [15:0] wd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    adr = 16'h0000;
    wd = 16'h0000;
  end

  // Stands in for the external address latch of the control lines
  always @(posedge clk) begin
    if (ale)
      adr <= {hi_out, lo_out};
    if (!wr_n)
      wd <= {hi_out, lo_out};
  end

  // Released lines show the inverse, so stale data can never match
  always_comb begin
    if (!rd_n)
      {hi_in, lo_in} = adr ^ 16'ha55a;
    else
      {hi_in, lo_in} = ~(adr ^ 16'ha55a);
  end
endmodule : ide_dev_model
`default_nettype wire
